// *** include/pgd_pkg.sv ***
// package: constants and types for the page register and address decode
package pgd_pkg;
  localparam logic [7:0] PGD_PAGE_OFS = 8'hE0;
  localparam logic [7:0] PGD_PWR0_OFS = 8'hB0;
  localparam logic [7:0] PGD_PWR2_OFS = 8'hB4;
  localparam logic [7:0] PGD_OUTMC_AB_OFS = 8'h20;
  localparam logic [7:0] PGD_OUTMC_BC_OFS = 8'h21;
  localparam logic [7:0] PGD_INMC_A_OFS = 8'h0A;
  localparam logic [7:0] PGD_INMC_B_OFS = 8'h0B;
  localparam logic [7:0] PGD_INMC_C_OFS = 8'h18;
  localparam int PGD_FAST_BIT = 3;
  localparam logic [7:0] PGD_PAGE_RST = 8'h00;
  localparam logic [7:0] PGD_PWR0_RST = 8'h08;
  localparam logic [4:0] PGD_PWR2_RST = 5'h00;
  localparam logic [7:0] PGD_OUTMC_RST = 8'h00;
  localparam int PGD_NPRI = 8;
  localparam int PGD_NSEC = 4;
  localparam int PGD_NOMC = 16;
  localparam int PGD_NIMC = 20;
  localparam int PGD_NTERMS = 137;
  localparam int PGD_IDLE_NS = 70;
  localparam int PGD_CLK_NS = 40;
  // longest time rounds down, at least one cycle
  localparam int PGD_IDLE_CYC =
    (PGD_IDLE_NS / PGD_CLK_NS) < 1 ? 1 : (PGD_IDLE_NS / PGD_CLK_NS);
  // window compare term: base and mask on address, page mask/value
  typedef struct packed {
    logic [15:0] base;
    logic [15:0] amask;
    logic [7:0] pval;
    logic [7:0] pmask;
  } pgd_term_t;
  typedef enum logic [1:0] {
    PGD_ST_RUN = 2'b00,
    PGD_ST_IDLE = 2'b01,
    PGD_ST_STBY = 2'b10
  } pgd_pwr_t;
endpackage : pgd_pkg

// *** core/pgd_terms.sv ***
// product-term evaluator: OR of up to N masked window terms
`timescale 1ns/10ps
module pgd_terms
  import pgd_pkg::*;
#(
  parameter int N = 3,
  parameter pgd_term_t [N-1:0] TERMS = '0
) (
  input wire logic [15:0] addr,
  input wire logic [7:0] page,
  output logic hit
);
  logic [N-1:0] t;
  // one compare per term; zero masks mean an unused term
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_t
      assign t[i] = ((TERMS[i].amask | {8'h00, TERMS[i].pmask}) != 16'h0000)
        && ((addr & TERMS[i].amask) == (TERMS[i].base & TERMS[i].amask))
        && ((page & TERMS[i].pmask) == (TERMS[i].pval & TERMS[i].pmask));
    end
  endgenerate
  assign hit = |t;
endmodule : pgd_terms

// *** core/pgd_idle.sv ***
// input-activity watch that puts the arrays into standby
`timescale 1ns/10ps
module pgd_idle
  import pgd_pkg::*;
#(
  parameter int W = 48
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fast,
  input wire logic [W-1:0] ins,
  output logic standby
);
  typedef struct packed {
    logic [W-1:0] prev;
    logic [3:0] cnt;
    pgd_pwr_t st;
  } pgd_idle_t;
  pgd_idle_t s_q, s_d;
  // count quiet cycles; any change wakes at once
  always_comb begin
    s_d = s_q;
    s_d.prev = ins;
    case (s_q.st)
      PGD_ST_RUN: begin
        s_d.cnt = 4'h0;
        if (!fast) s_d.st = PGD_ST_IDLE;
      end
      PGD_ST_IDLE: begin
        if (fast || ins != s_q.prev) begin
          s_d.st = fast ? PGD_ST_RUN : PGD_ST_IDLE;
          s_d.cnt = 4'h0;
        end else if (s_q.cnt >= 4'(PGD_IDLE_CYC - 1)) begin
          s_d.st = PGD_ST_STBY;
        end else begin
          s_d.cnt = s_q.cnt + 4'h1;
        end
      end
      PGD_ST_STBY: begin
        // a wake costs a cycle: the slower-path trade for less power
        if (fast || ins != s_q.prev) s_d.st = PGD_ST_RUN;
      end
      default: s_d.st = PGD_ST_RUN;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s_q <= '0;
    else s_q <= s_d;
  end
  // standby is the only code with bit 1 set, so the flop drives it directly
  assign standby = s_q.st[1];
endmodule : pgd_idle

// *** core/pgd_top.sv ***
// page register, register window and decode / general logic arrays
`timescale 1ns/10ps
module pgd_top
  import pgd_pkg::*;
#(
  parameter pgd_term_t [PGD_NPRI*3-1:0] PRI_TERMS = '0,
  parameter pgd_term_t [PGD_NSEC*3-1:0] SEC_TERMS = '0,
  parameter pgd_term_t [1:0] SRAM_TERMS = '0,
  parameter logic [15:0] REG_BASE = 16'h2000,
  parameter logic [15:0] PER_BASE0 = 16'h4000,
  parameter logic [15:0] PER_BASE1 = 16'h4100,
  parameter logic [15:0] ECS_BASE0 = 16'h6000,
  parameter logic [15:0] ECS_BASE1 = 16'h6100
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic PROGRAM_FETCH_STROBE,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic ALE,
  input wire logic POWER_DOWN_INPUT,
  input wire logic PERIPH_MODE,
  input wire logic [19:0] INPUT_MACROCELL,
  input wire logic [1:0] PORT_D_IN,
  input wire logic FLASH_READY,
  output logic [7:0] RDATA,
  output logic [7:0] PAGE_BITS,
  output logic [7:0] PRIMARY_SECTOR_SELECTS,
  output logic [3:0] SECONDARY_SECTOR_SELECTS,
  output logic SRAM_SELECT,
  output logic REGISTER_SPACE_SELECT,
  output logic [1:0] PERIPH_SELECTS,
  output logic [1:0] EXTERNAL_CHIP_SELECTS,
  output logic [15:0] OUTPUT_MACROCELL,
  output logic ARRAY_STANDBY
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] pwr0;
    logic [4:0] pwr2;
    logic [15:0] mcell;
    logic [7:0] rdata;
    logic [7:0] pri;
    logic [3:0] sec;
    logic sram;
    logic regsel;
    logic [1:0] per;
    logic [1:0] ecs;
    logic wr_prev;
  } pgd_top_t;
  pgd_top_t s_q, s_d;
  logic rst_n;
  logic [1:0] sync_q;
  logic [7:0] pri_raw;
  logic [3:0] sec_raw;
  logic sram_raw;
  logic standby;
  logic [4:0] strobes;
  logic [68:0] watch;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; they only take constants
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) sync_q <= 2'b00;
    else sync_q <= {sync_q[0], 1'b1};
  end
  assign rst_n = sync_q[1];

  // window decode on the high address byte, used for the register, peripheral and external windows
  function automatic logic in_win(input logic [15:0] a,
                                  input logic [15:0] base);
    in_win = (a[15:8] == base[15:8]);
  endfunction : in_win

  ////////////////////////////////////////////////////////////////////////////
  // control strobes after the power reg two gates (1 blocks)
  assign strobes = {PROGRAM_FETCH_STROBE, ~RD_N, ~WR_N, ALE, 1'b0}
                   & ~s_q.pwr2;

  // every array input except PERIPH_MODE, watched for activity
  assign watch = {ADDR, strobes[4:1], POWER_DOWN_INPUT, INPUT_MACROCELL,
                  PORT_D_IN, s_q.page, s_q.mcell, FLASH_READY, rst_n};

  pgd_idle #(
    .W(69)
  ) u_idle (
    .clk(MCLK),
    .rst_n(rst_n),
    .fast(s_q.pwr0[PGD_FAST_BIT]),
    .ins(watch),
    .standby(standby)
  );

  ////////////////////////////////////////////////////////////////////////////
  // memory sector terms; page bits enter every equation
  genvar i;
  generate
    for (i = 0; i < PGD_NPRI; i++) begin : g_pri
      pgd_terms #(
        .N(3),
        .TERMS(PRI_TERMS[i*3 +: 3])
      ) u_t (
        .addr(ADDR),
        .page(s_q.page),
        .hit(pri_raw[i])
      );
    end
    for (i = 0; i < PGD_NSEC; i++) begin : g_sec
      pgd_terms #(
        .N(3),
        .TERMS(SEC_TERMS[i*3 +: 3])
      ) u_t (
        .addr(ADDR),
        .page(s_q.page),
        .hit(sec_raw[i])
      );
    end
  endgenerate

  pgd_terms #(
    .N(2),
    .TERMS(SRAM_TERMS)
  ) u_sram (
    .addr(ADDR),
    .page(s_q.page),
    .hit(sram_raw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: bus writes, readback and prioritised selects
  always_comb begin
    logic wr_edge;
    logic io_hit;
    logic [1:0] per_hit;
    logic [1:0] ecs_hit;
    logic [7:0] ofs;
    wr_edge = 1'b0;
    io_hit = 1'b0;
    per_hit = 2'b00;
    ecs_hit = 2'b00;
    ofs = ADDR[7:0];
    s_d = s_q;
    s_d.wr_prev = ~WR_N;
    wr_edge = s_q.wr_prev & WR_N; // trailing edge of the write strobe
    io_hit = in_win(ADDR, REG_BASE);
    per_hit[0] = PERIPH_MODE && in_win(ADDR, PER_BASE0);
    per_hit[1] = PERIPH_MODE && in_win(ADDR, PER_BASE1);
    // port D selects come from direct terms, not output macrocells
    ecs_hit[0] = in_win(ADDR, ECS_BASE0) && (strobes[3] | strobes[2]);
    ecs_hit[1] = in_win(ADDR, ECS_BASE1) && (strobes[3] | strobes[2]);
    // register writes at the trailing edge of the strobe
    if (wr_edge && io_hit) begin
      case (ofs)
        PGD_PAGE_OFS: s_d.page = WDATA;
        PGD_PWR0_OFS: s_d.pwr0 = WDATA;
        PGD_PWR2_OFS: s_d.pwr2 = WDATA[4:0];
        PGD_OUTMC_AB_OFS: s_d.mcell[7:0] = WDATA;
        PGD_OUTMC_BC_OFS: s_d.mcell[15:8] = WDATA;
        default: ;
      endcase
    end
    // readback of page, power regs and macrocells
    s_d.rdata = 8'h00;
    if (io_hit && !RD_N) begin
      case (ofs)
        PGD_PAGE_OFS: s_d.rdata = s_q.page;
        PGD_PWR0_OFS: s_d.rdata = s_q.pwr0;
        PGD_PWR2_OFS: s_d.rdata = {3'b000, s_q.pwr2};
        PGD_OUTMC_AB_OFS: s_d.rdata = s_q.mcell[7:0];
        PGD_OUTMC_BC_OFS: s_d.rdata = s_q.mcell[15:8];
        PGD_INMC_A_OFS: s_d.rdata = INPUT_MACROCELL[7:0];
        PGD_INMC_B_OFS: s_d.rdata = INPUT_MACROCELL[15:8];
        PGD_INMC_C_OFS: s_d.rdata = {4'h0, INPUT_MACROCELL[19:16]};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // sram/io/peripherals beat every sector; secondary beats primary
    s_d.sram = sram_raw && !io_hit && !(|per_hit);
    s_d.regsel = io_hit;
    s_d.per = per_hit;
    s_d.sec = (sram_raw | io_hit | (|per_hit)) ? 4'h0 : sec_raw;
    s_d.pri = (sram_raw | io_hit | (|per_hit) | (|sec_raw))
              ? 8'h00 : pri_raw;
    s_d.ecs = ecs_hit;
    // standby holds the selects: a wake makes them one cycle late
    if (standby) begin
      s_d.sram = s_q.sram;
      s_d.regsel = s_q.regsel;
      s_d.per = s_q.per;
      s_d.sec = s_q.sec;
      s_d.pri = s_q.pri;
      s_d.ecs = s_q.ecs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers: constant reset values, equations live from reset
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q.page <= PGD_PAGE_RST;
      s_q.pwr0 <= PGD_PWR0_RST;
      s_q.pwr2 <= PGD_PWR2_RST;
      s_q.mcell <= {PGD_OUTMC_RST, PGD_OUTMC_RST};
      s_q.rdata <= 8'h00;
      s_q.pri <= 8'h00;
      s_q.sec <= 4'h0;
      s_q.sram <= 1'b0;
      s_q.regsel <= 1'b0;
      s_q.per <= 2'b00;
      s_q.ecs <= 2'b00;
      s_q.wr_prev <= 1'b0;
    end else begin
      s_q.page <= s_d.page;
      s_q.pwr0 <= s_d.pwr0;
      s_q.pwr2 <= s_d.pwr2;
      s_q.mcell <= s_d.mcell;
      s_q.rdata <= s_d.rdata;
      s_q.pri <= s_d.pri;
      s_q.sec <= s_d.sec;
      s_q.sram <= s_d.sram;
      s_q.regsel <= s_d.regsel;
      s_q.per <= s_d.per;
      s_q.ecs <= s_d.ecs;
      s_q.wr_prev <= s_d.wr_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign RDATA = s_q.rdata;
  assign PAGE_BITS = s_q.page;
  assign PRIMARY_SECTOR_SELECTS = s_q.pri;
  assign SECONDARY_SECTOR_SELECTS = s_q.sec;
  assign SRAM_SELECT = s_q.sram;
  assign REGISTER_SPACE_SELECT = s_q.regsel;
  assign PERIPH_SELECTS = s_q.per;
  assign EXTERNAL_CHIP_SELECTS = s_q.ecs;
  assign OUTPUT_MACROCELL = s_q.mcell;
  assign ARRAY_STANDBY = standby;
endmodule : pgd_top

// *** sim/pgd_top_asserts.sv ***
// checker: port-level properties of the page register and decode
`timescale 1ns/10ps
module pgd_top_asserts
  import pgd_pkg::*;
#(
  parameter logic [15:0] REG_BASE = 16'h2000
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic PERIPH_MODE,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] PAGE_BITS,
  input wire logic [7:0] PRIMARY_SECTOR_SELECTS,
  input wire logic [3:0] SECONDARY_SECTOR_SELECTS,
  input wire logic SRAM_SELECT,
  input wire logic REGISTER_SPACE_SELECT,
  input wire logic [1:0] PERIPH_SELECTS,
  input wire logic [1:0] EXTERNAL_CHIP_SELECTS,
  input wire logic ARRAY_STANDBY
);
  logic [15:0] pg_a;
  // one clock domain; the synchronised reset lags two edges
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  assign pg_a = {REG_BASE[15:8], PGD_PAGE_OFS};
  // strobe low, then its trailing edge with address and data held
  sequence page_wr_s;
    !WR_N && ADDR == pg_a ##1 WR_N && $stable(ADDR) && $stable(WDATA);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  page_write_a: assert property (
    page_wr_s |=> PAGE_BITS == $past(WDATA)) else $error("page write lost");
  page_hold_a: assert property ($changed(PAGE_BITS) |->
    $past(WR_N) && !$past(WR_N, 2) && $past(ADDR) == pg_a)
    else $error("page moved");
  page_read_a: assert property (!RD_N && ADDR == pg_a |=>
    RDATA == $past(PAGE_BITS)) else $error("page readback wrong");
  unmapped_read_a: assert property (!RD_N && ADDR == pg_a + 16'h0001 |=>
    RDATA == 8'h00) else $error("unmapped read not zero");
  regspace_sel_a: assert property ($past(RSTN, 2) && !ARRAY_STANDBY &&
    ADDR[15:8] == REG_BASE[15:8] ##1 !ARRAY_STANDBY |-> REGISTER_SPACE_SELECT)
    else $error("register window not selected");
  mem_priority_a: assert property ($onehot0({PRIMARY_SECTOR_SELECTS,
    SECONDARY_SECTOR_SELECTS, SRAM_SELECT, REGISTER_SPACE_SELECT}))
    else $error("overlapping selects");
  periph_mode_a: assert property (|PERIPH_SELECTS |->
    $past(PERIPH_MODE)) else $error("peripheral select outside mode");
  ecs_strobe_a: assert property (|EXTERNAL_CHIP_SELECTS |->
    !$past(RD_N) || !$past(WR_N)) else $error("external select w/o strobe");
endmodule : pgd_top_asserts

bind pgd_top pgd_top_asserts #(.REG_BASE(REG_BASE)) u_chk (.*);

// *** sim/pgd_mcu.sv ***
// core bus-master model: address, data and strobes for the decode
`timescale 1ns/10ps
module pgd_mcu (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic [1:0] ecs,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic rd_n,
  output logic wr_n,
  output logic ale,
  output logic fetch
);
  // bus idles with strobes inactive; latch and fetch stay quiet
  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ale = 1'b0;
    fetch = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // address only; decode answers one edge later
  task automatic go(input logic [15:0] a);
    @(posedge clk);
    #1 addr = a;
    @(posedge clk);
    #1;
  endtask : go
  // address and data held past the trailing edge, which loads
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr_n = 1'b0;
    @(posedge clk);
    #1 wr_n = 1'b1;
    @(posedge clk);
    #1;
  endtask : wr
  // answer taken just after the first edge that sees the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
    output logic [1:0] e);
    @(posedge clk);
    #1 addr = a;
    rd_n = 1'b0;
    @(posedge clk);
    #1 d = rdata;
    e = ecs;
    rd_n = 1'b1;
  endtask : rd
endmodule : pgd_mcu

// *** sim/pgd_top_tb.sv ***
// self-checking bench: page register, window reads and decode selects
`timescale 1ns/10ps
module pgd_top_tb
  import pgd_pkg::*;
;
  localparam pgd_term_t TP = '{16'h8000, 16'hC000, 8'h01, 8'hFF};
  localparam pgd_term_t TS = '{16'h8000, 16'hE000, 8'h01, 8'hFF};
  localparam pgd_term_t TR = '{16'h8000, 16'hF800, 8'h01, 8'hFF};
  logic MCLK, RSTN, ALE, PROGRAM_FETCH_STROBE, RD_N, WR_N, PERIPH_MODE;
  logic SRAM_SELECT, REGISTER_SPACE_SELECT, ARRAY_STANDBY;
  logic [15:0] ADDR, OUTPUT_MACROCELL;
  logic [7:0] WDATA, RDATA, PAGE_BITS, PRIMARY_SECTOR_SELECTS, r;
  logic [3:0] SECONDARY_SECTOR_SELECTS;
  logic [1:0] PERIPH_SELECTS, EXTERNAL_CHIP_SELECTS, e;
  logic POWER_DOWN_INPUT;
  logic [19:0] INPUT_MACROCELL;
  int fails = 0;
  int n_tests = 0;
  // page 01 maps sector, boot sector and sram all over 8000
  pgd_top #(.PRI_TERMS({{23{48'h0}}, TP}), .SEC_TERMS({{11{48'h0}}, TS}),
    .SRAM_TERMS({48'h0, TR})) dut (.PORT_D_IN(2'b00), .FLASH_READY(1'b1),
    .*);
  pgd_mcu mcu (.clk(MCLK), .rdata(RDATA), .ecs(EXTERNAL_CHIP_SELECTS),
    .addr(ADDR), .wdata(WDATA), .rd_n(RD_N), .wr_n(WR_N), .ale(ALE),
    .fetch(PROGRAM_FETCH_STROBE));
  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    n_tests++;
    if (s !== x) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // read through the core model and compare
  task automatic rdx(input logic [15:0] a, input logic [7:0] x);
    mcu.rd(a, r, e);
    chk(r, x);
  endtask : rdx
  // selects packed {primary, secondary, sram, register window}
  task automatic sel(input logic [15:0] a, input logic [13:0] x);
    mcu.go(a);
    chk({PRIMARY_SECTOR_SELECTS, SECONDARY_SECTOR_SELECTS, SRAM_SELECT,
      REGISTER_SPACE_SELECT}, x);
  endtask : sel
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // 25 MHz core clock
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  // whole run is about a hundred cycles; a hang ends here
  initial begin
    #400000;
    fails++;
    summarize();
  end
  initial begin
    RSTN = 1'b0;
    PERIPH_MODE = 1'b0;
    POWER_DOWN_INPUT = 1'b0;
    INPUT_MACROCELL = 20'h53CA7;
    repeat (6) @(posedge MCLK);
    #1 RSTN = 1'b1;
    repeat (2) @(posedge MCLK);
    #1 chk(PAGE_BITS, 8'h00);
    rdx(16'h20E0, 8'h00);
    rdx(16'h20B0, 8'h08);
    $display("test reset done");
    // readback, an unmapped offset and an address outside the window
    mcu.wr(16'h20E0, 8'hA5);
    chk(PAGE_BITS, 8'hA5);
    rdx(16'h20E0, 8'hA5);
    mcu.wr(16'h20E1, 8'h3C);
    rdx(16'h20E1, 8'h00);
    rdx(16'h30E0, 8'h00);
    chk(PAGE_BITS, 8'hA5);
    $display("test page done");
    // overlaps resolve sram over boot sector over main sector
    mcu.wr(16'h20E0, 8'h01);
    sel(16'h8000, 14'h0002);
    sel(16'h8800, 14'h0004);
    sel(16'hA000, 14'h0040);
    sel(16'h2000, 14'h0001);
    mcu.wr(16'h20E0, 8'h00);
    sel(16'hA000, 14'h0000);
    $display("test decode done");
    PERIPH_MODE = 1'b1;
    mcu.go(16'h4000);
    chk(PERIPH_SELECTS, 2'b01);
    mcu.go(16'h4100);
    chk(PERIPH_SELECTS, 2'b10);
    PERIPH_MODE = 1'b0;
    mcu.go(16'h4000);
    chk(PERIPH_SELECTS, 2'b00);
    // read strobe gated off the arrays blocks the external select
    mcu.rd(16'h6100, r, e);
    chk(e, 2'b10);
    mcu.wr(16'h20B4, 8'h08);
    mcu.rd(16'h6100, r, e);
    chk(e, 2'b00);
    mcu.wr(16'h20B4, 8'h00);
    mcu.wr(16'h2020, 8'h5A);
    chk(OUTPUT_MACROCELL[7:0], 8'h5A);
    rdx(16'h2020, 8'h5A);
    mcu.wr(16'h2021, 8'hC3);
    chk(OUTPUT_MACROCELL[15:8], 8'hC3);
    rdx(16'h2021, 8'hC3);
    // input macrocells read back in three slices
    rdx(16'h200A, 8'hA7);
    rdx(16'h200B, 8'h3C);
    rdx(16'h2018, 8'h05);
    $display("test selects done");
    // fast bit off: quiet inputs put the arrays to sleep
    mcu.wr(16'h20B0, 8'h00);
    repeat (4) @(posedge MCLK);
    #1 chk(ARRAY_STANDBY, 1'b1);
    // any watched input, power-down too, wakes the arrays
    POWER_DOWN_INPUT = 1'b1;
    @(posedge MCLK);
    #1 chk(ARRAY_STANDBY, 1'b0);
    mcu.wr(16'h20B0, 8'h08);
    chk(ARRAY_STANDBY, 1'b0);
    $display("test standby done");
    // reset in mid-run drops the page and power reg back
    mcu.wr(16'h20E0, 8'h5A);
    RSTN = 1'b0;
    repeat (3) @(posedge MCLK);
    #1 RSTN = 1'b1;
    repeat (2) @(posedge MCLK);
    #1 chk(PAGE_BITS, 8'h00);
    rdx(16'h20E0, 8'h00);
    rdx(16'h20B0, 8'h08);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : pgd_top_tb
